// ===== src/svcu_pkg.sv
// constants and types for the packed vector compare slice
//
// Function
// - halfword group sub-op 01000 equal, 01001 less, 01010 less-or-equal in bits 10..6
// - all variants: major 011111 bits 31..26, function 010001 bits 5..0; halfword rd 00000
// - byte dual-write group sub-op 11000 equal, 11001 less, 11010 less-or-equal
// - halfword group compares two signed 16-bit elements pairwise from low 32 bits
// - relation applied per element, first source on the left, one flag each
// - halfword flags: upper pair to bit 25, lower to bit 24; no register write
// - after halfword compare bits 26..31 are unspecified
// - condition code field is 8 bits at control bits 31..24, flags from bit 24 up
// - byte group compares four unsigned 8-bit elements without sign extension
// - byte flags, top element highest, to control bits 27..24 and register bits 3..0
// - byte group clears destination register bits above the four flags
// - after byte compare bits 28..31 are unspecified
// - no operand-dependent exception; outcomes only as flags
`default_nettype none

package svcu_pkg;
  localparam int unsigned GPR_WIDTH      = 64;
  localparam int unsigned CC_WIDTH       = 8;
  localparam int unsigned CC_LSB         = 24;
  localparam int unsigned CTRL_WIDTH     = 32;
  localparam int unsigned NUM_HALF       = 2;
  localparam int unsigned NUM_BYTE       = 4;
  localparam int unsigned HALF_BITS      = 16;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned SRC_BITS       = 32;

  // instruction word field positions and widths
  localparam int unsigned MAJOR_LSB      = 26;
  localparam int unsigned MAJOR_BITS     = 6;
  localparam int unsigned FUNC_LSB       = 0;
  localparam int unsigned FUNC_BITS      = 6;
  localparam int unsigned DEST_LSB       = 11;
  localparam int unsigned SUBOP_LSB      = 6;
  localparam int unsigned FIELD_BITS     = 5;

  localparam logic [5:0] EXTENDED_MAJOR_OPCODE        = 6'h1f;
  localparam logic [5:0] VECTOR_COMPARE_FUNCTION_CODE = 6'h11;
  localparam logic [4:0] HALF_DEST_ZERO               = 5'h00;

  localparam logic [4:0] SUBOP_HALF_EQ = 5'h08;
  localparam logic [4:0] SUBOP_HALF_LT = 5'h09;
  localparam logic [4:0] SUBOP_HALF_LE = 5'h0a;
  localparam logic [4:0] SUBOP_BYTE_EQ = 5'h18;
  localparam logic [4:0] SUBOP_BYTE_LT = 5'h19;
  localparam logic [4:0] SUBOP_BYTE_LE = 5'h1a;

  typedef enum logic [1:0] {SVCU_REL_EQ, SVCU_REL_LT, SVCU_REL_LE} svcu_rel_e;
endpackage

`default_nettype wire

// ===== src/svcu_lane_cmp.sv
// one compare lane: equal, less or less-or-equal on a signed or unsigned element
`default_nettype none

module svcu_lane_cmp #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0]           i_left,
  input  wire logic [W-1:0]           i_right,
  input  wire logic                   i_signed,
  input  wire svcu_pkg::svcu_rel_e    i_rel,
  output logic                        o_flag
);
  logic lt;

  // first source on the left; sign flip turns signed into unsigned order
  assign lt = ({i_left[W-1] ^ i_signed, i_left[W-2:0]} < {i_right[W-1] ^ i_signed, i_right[W-2:0]});

  always_comb
  begin
    unique case (i_rel)
      svcu_pkg::SVCU_REL_EQ: o_flag = (i_left == i_right);
      svcu_pkg::SVCU_REL_LT: o_flag = lt;
      svcu_pkg::SVCU_REL_LE: o_flag = lt | (i_left == i_right);
      default:               o_flag = 1'h0;
    endcase
  end
endmodule

`default_nettype wire

// ===== src/svcu_top.sv
// packed vector compare slice: decode, lane compares, register and condition-code update
`default_nettype none

module svcu_top (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  input  wire logic        I_ISSUE,
  input  wire logic [31:0] I_INSTR,
  input  wire logic [63:0] I_FIRST_SOURCE_REGISTER,
  input  wire logic [63:0] I_SECOND_SOURCE_REGISTER,
  input  wire logic [31:0] I_CTRL_IN,
  output logic             O_ACCEPT,
  output logic             O_GPR_WE,
  output logic [4:0]       O_GPR_ADDR,
  output logic [63:0]      O_GPR_DATA,
  output logic             O_CTRL_WE,
  output logic [31:0]      O_CTRL_DATA
);
  // instruction fields, cut out once so that every decoder reads the same bits
  logic [svcu_pkg::MAJOR_BITS-1:0] major;
  logic [svcu_pkg::FUNC_BITS-1:0]  func;
  logic [svcu_pkg::FIELD_BITS-1:0] dest;
  logic [svcu_pkg::FIELD_BITS-1:0] subop;
  // only the low word of each source takes part; the upper half is ignored by both groups
  logic [svcu_pkg::SRC_BITS-1:0]   left_word;
  logic [svcu_pkg::SRC_BITS-1:0]   right_word;
  logic                            is_cmp;
  logic                            is_half;
  logic                            is_byte;
  logic                            take;
  logic                            take_byte;
  svcu_pkg::svcu_rel_e             rel;
  logic [svcu_pkg::NUM_BYTE-1:0]   byte_flags;
  logic [svcu_pkg::NUM_HALF-1:0]   half_flags;
  logic [svcu_pkg::CC_WIDTH-1:0]   cc_nxt;
  logic [svcu_pkg::CTRL_WIDTH-1:0] ctrl_nxt;
  logic [svcu_pkg::GPR_WIDTH-1:0]  gpr_nxt;

  // codes outside both groups fall to less-or-equal; they never raise a strobe
  function automatic svcu_pkg::svcu_rel_e rel_of(input logic [svcu_pkg::FIELD_BITS-1:0] code);
    case (code)
      svcu_pkg::SUBOP_HALF_EQ,
      svcu_pkg::SUBOP_BYTE_EQ: rel_of = svcu_pkg::SVCU_REL_EQ;
      svcu_pkg::SUBOP_HALF_LT,
      svcu_pkg::SUBOP_BYTE_LT: rel_of = svcu_pkg::SVCU_REL_LT;
      default:                 rel_of = svcu_pkg::SVCU_REL_LE;
    endcase
  endfunction

  // sub-op sets of the two groups
  function automatic logic half_subop(input logic [svcu_pkg::FIELD_BITS-1:0] code);
    half_subop = (code == svcu_pkg::SUBOP_HALF_EQ)
              || (code == svcu_pkg::SUBOP_HALF_LT)
              || (code == svcu_pkg::SUBOP_HALF_LE);
  endfunction

  function automatic logic byte_subop(input logic [svcu_pkg::FIELD_BITS-1:0] code);
    byte_subop = (code == svcu_pkg::SUBOP_BYTE_EQ)
              || (code == svcu_pkg::SUBOP_BYTE_LT)
              || (code == svcu_pkg::SUBOP_BYTE_LE);
  endfunction

  assign major      = I_INSTR[svcu_pkg::MAJOR_LSB +: svcu_pkg::MAJOR_BITS];
  assign func       = I_INSTR[svcu_pkg::FUNC_LSB +: svcu_pkg::FUNC_BITS];
  assign dest       = I_INSTR[svcu_pkg::DEST_LSB +: svcu_pkg::FIELD_BITS];
  assign subop      = I_INSTR[svcu_pkg::SUBOP_LSB +: svcu_pkg::FIELD_BITS];
  assign left_word  = I_FIRST_SOURCE_REGISTER[svcu_pkg::SRC_BITS-1:0];
  assign right_word = I_SECOND_SOURCE_REGISTER[svcu_pkg::SRC_BITS-1:0];

  // the shared major and function codes gate both groups
  assign is_cmp  = (major == svcu_pkg::EXTENDED_MAJOR_OPCODE)
                 && (func == svcu_pkg::VECTOR_COMPARE_FUNCTION_CODE);
  // a halfword word with a non-zero destination field is refused outright
  assign is_half = is_cmp && (dest == svcu_pkg::HALF_DEST_ZERO) && half_subop(subop);
  // the byte group takes any destination field
  assign is_byte = is_cmp && byte_subop(subop);
  // one qualifier for accept, the control strobe and the data registers; the register write strobe uses take_byte
  assign take      = I_ISSUE && (is_half || is_byte);
  assign take_byte = I_ISSUE && is_byte;
  assign rel       = rel_of(subop);

  genvar g;
  generate
    // byte lanes compare without sign
    for (g = 0; g < svcu_pkg::NUM_BYTE; g++)
    begin : g_byte
      svcu_lane_cmp #(.W(svcu_pkg::BYTE_BITS)) u_lane (
        .i_left   (left_word[g*svcu_pkg::BYTE_BITS +: svcu_pkg::BYTE_BITS]),
        .i_right  (right_word[g*svcu_pkg::BYTE_BITS +: svcu_pkg::BYTE_BITS]),
        .i_signed (1'h0),
        .i_rel    (rel),
        .o_flag   (byte_flags[g])
      );
    end
    // halfword lanes compare in two's complement
    for (g = 0; g < svcu_pkg::NUM_HALF; g++)
    begin : g_half
      svcu_lane_cmp #(.W(svcu_pkg::HALF_BITS)) u_lane (
        .i_left   (left_word[g*svcu_pkg::HALF_BITS +: svcu_pkg::HALF_BITS]),
        .i_right  (right_word[g*svcu_pkg::HALF_BITS +: svcu_pkg::HALF_BITS]),
        .i_signed (1'h1),
        .i_rel    (rel),
        .o_flag   (half_flags[g])
      );
    end
  endgenerate

  // undefined condition bits keep the incoming value, so results are repeatable
  always_comb
  begin
    cc_nxt = I_CTRL_IN[svcu_pkg::CC_LSB +: svcu_pkg::CC_WIDTH];
    if (is_half)
    begin
      cc_nxt[svcu_pkg::NUM_HALF-1:0] = half_flags;
    end
    else if (is_byte)
    begin
      cc_nxt[svcu_pkg::NUM_BYTE-1:0] = byte_flags;
    end
  end

  // bits below the condition field pass through untouched
  always_comb
  begin
    ctrl_nxt = I_CTRL_IN;
    ctrl_nxt[svcu_pkg::CC_LSB +: svcu_pkg::CC_WIDTH] = cc_nxt;
  end

  // everything above the four flags is zero
  always_comb
  begin
    gpr_nxt = '0;
    gpr_nxt[svcu_pkg::NUM_BYTE-1:0] = byte_flags;
  end

  // no exception path exists: every outcome leaves as flag bits
  // accept pulses once per recognised issue; refused words leave it low
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_ACCEPT <= '0;
    end
    else
    begin
      O_ACCEPT <= take;
    end
  end

  // both groups update the condition field
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_CTRL_WE <= '0;
    end
    else
    begin
      O_CTRL_WE <= take;
    end
  end

  // only the byte group writes a general register
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_GPR_WE <= '0;
    end
    else
    begin
      O_GPR_WE <= take_byte;
    end
  end

  // halfword words carry a zero destination here, and their write enable stays low
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_GPR_ADDR <= '0;
    end
    else if (take)
    begin
      O_GPR_ADDR <= dest;
    end
  end

  // data holds between issues, so a late reader still sees the last result
  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_GPR_DATA <= '0;
    end
    else if (take)
    begin
      O_GPR_DATA <= gpr_nxt;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_CTRL_DATA <= '0;
    end
    else if (take)
    begin
      O_CTRL_DATA <= ctrl_nxt;
    end
  end
endmodule

`default_nettype wire

// ===== tb/svcu_properties.sv
// assertion checker for the vector compare slice
`default_nettype none
module svcu_properties (
  input wire logic        I_CLOCK,
  input wire logic        I_RST_N,
  input wire logic        I_ISSUE,
  input wire logic [31:0] I_INSTR,
  input wire logic [63:0] I_FIRST_SOURCE_REGISTER,
  input wire logic [63:0] I_SECOND_SOURCE_REGISTER,
  input wire logic [31:0] I_CTRL_IN,
  input wire logic        O_ACCEPT,
  input wire logic        O_GPR_WE,
  input wire logic [63:0] O_GPR_DATA,
  input wire logic        O_CTRL_WE,
  input wire logic [31:0] O_CTRL_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [31:0] a = I_FIRST_SOURCE_REGISTER[31:0];
  wire logic [31:0] b = I_SECOND_SOURCE_REGISTER[31:0];
  wire logic [9:0]  f = I_INSTR[15:6];
  wire logic        hit = I_ISSUE && I_INSTR[31:26] == 6'h1f && I_INSTR[5:0] == 6'h11;
  wire logic [1:0]  heq = {a[31:16] == b[31:16], a[15:0] == b[15:0]};
  wire logic [1:0]  hlt = {$signed(a[31:16]) < $signed(b[31:16]), $signed(a[15:0]) < $signed(b[15:0])};
  wire logic [3:0]  blt = {a[31:24] < b[31:24], a[23:16] < b[23:16], a[15:8] < b[15:8], a[7:0] < b[7:0]};
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  property p_eq_h; $past(hit && f == 10'h008) |-> O_CTRL_DATA[25:24] == $past(heq); endproperty
  a_eq_h: assert property (p_eq_h) else $error("halfword equal flags");
  // less-or-equal built from the equal and less relations, an independent path
  property p_le_h; $past(hit && f == 10'h00a) |-> O_CTRL_DATA[25:24] == $past(heq | hlt); endproperty
  a_le_h: assert property (p_le_h) else $error("halfword signed flags");
  property p_lt_b; $past(hit && f[4:0] == 5'h19) |-> O_GPR_DATA[3:0] == $past(blt); endproperty
  a_lt_b: assert property (p_lt_b) else $error("byte unsigned flags");
  property p_dual; O_GPR_WE |-> O_GPR_DATA == {60'h0, O_CTRL_DATA[27:24]}; endproperty
  a_dual: assert property (p_dual) else $error("register copy differs");
  property p_nogpr; $past(hit && f inside {10'h008, 10'h009, 10'h00a}) |-> O_ACCEPT && !O_GPR_WE; endproperty
  a_nogpr: assert property (p_nogpr) else $error("halfword register write");
  property p_refuse; !$past(hit) |-> !O_ACCEPT && !O_CTRL_WE; endproperty
  a_refuse: assert property (p_refuse) else $error("strobe without issue");
  property p_keep; O_CTRL_WE && O_GPR_WE |-> O_CTRL_DATA[31:28] == $past(I_CTRL_IN[31:28]); endproperty
  a_keep: assert property (p_keep) else $error("upper field changed");
  property p_field; O_ACCEPT |-> O_CTRL_WE && O_CTRL_DATA[23:0] == $past(I_CTRL_IN[23:0]); endproperty
  a_field: assert property (p_field) else $error("bits below field changed");
endmodule
bind svcu_top svcu_properties u_props (.I_CLOCK, .I_RST_N, .I_ISSUE, .I_INSTR, .I_FIRST_SOURCE_REGISTER,
  .I_SECOND_SOURCE_REGISTER, .I_CTRL_IN, .O_ACCEPT, .O_GPR_WE, .O_GPR_DATA, .O_CTRL_WE, .O_CTRL_DATA);
`default_nettype wire

// ===== tb/svcu_ctrl_model.sv
// control register model that feeds and absorbs the slice's condition field
`default_nettype none
module svcu_ctrl_model #(
  parameter logic [31:0] INIT = 32'h9c3a_5e71
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_we,
  input  wire logic [31:0] i_data,
  output logic [31:0]      o_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  // non-zero reset value so that kept upper bits are visible
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n) o_ctrl <= INIT;
    else if (i_we) o_ctrl <= i_data;
endmodule
`default_nettype wire

// ===== tb/svcu_top_tb.sv
// random compare traffic checked against an integer model
`default_nettype none
module svcu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, issue, acc, gwe, cwe, e_acc, e_gwe;
  logic [31:0] instr, cin, cout, e_c;
  logic [4:0]  gaddr, e_a;
  logic [63:0] a, b, gdat, e_g;
  int          n_mismatch, n_tests, cyc, k, r;
  svcu_top uut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_ISSUE(issue), .I_INSTR(instr), .I_FIRST_SOURCE_REGISTER(a),
    .I_SECOND_SOURCE_REGISTER(b), .I_CTRL_IN(cin), .O_ACCEPT(acc), .O_GPR_WE(gwe), .O_GPR_ADDR(gaddr),
    .O_GPR_DATA(gdat), .O_CTRL_WE(cwe), .O_CTRL_DATA(cout));
  svcu_ctrl_model m (.i_clock(clk), .i_rst_n(rst_n), .i_we(cwe), .i_data(cout), .o_ctrl(cin));
  task automatic chk(logic [63:0] g, logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic compare_all();
    chk(64'(acc), 64'(e_acc));
    chk(64'(gwe), 64'(e_gwe));
    if (e_acc) chk(64'(cout), 64'(e_c));
    if (e_gwe) chk(gdat, e_g);
    if (e_gwe) chk(64'(gaddr), 64'(e_a));
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic bit rel(int s, int x, int y);
    return s == 0 ? x == y : s == 1 ? x < y : x <= y;
  endfunction
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (++cyc == 2000)
    begin
      n_mismatch++;
      results();
    end
  initial
  begin
    {rst_n, issue, instr, a, b, cyc, n_mismatch, n_tests, e_acc, e_gwe} = '0;
    void'($urandom(32'h4dff));
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    // back to back issues; k 6 and 7 are words the slice must ignore
    repeat (400)
    begin
      @(negedge clk);
      compare_all();
      k = $urandom % 8;
      r = k % 3;
      a = {$urandom, $urandom};
      b = {$urandom, a[31:0] ^ ($urandom & $urandom & $urandom)};
      instr = {6'h1f, 10'($urandom), k > 2 ? 5'($urandom | 1) : 5'h0, (k inside {[3:5]}) ? 2'h3 : 2'h1, 1'h0,
        r[1:0], k == 7 ? 6'h12 : 6'h11};
      issue = 1'h1;
      e_acc = k < 6;
      e_gwe = k inside {[3:5]};
      e_a = instr[15:11];
      e_c = cin;
      for (int i = 0; i < 4; i++)
        if (k < 3 && i < 2) e_c[24+i] = rel(r, int'($signed(a[16*i+:16])), int'($signed(b[16*i+:16])));
        else if (e_gwe) e_c[24+i] = rel(r, int'(a[8*i+:8]), int'(b[8*i+:8]));
      e_g = {60'h0, e_c[27:24]};
    end
    // the last result, then the strobes must fall once issue drops
    @(negedge clk);
    compare_all();
    issue = 1'h0;
    {e_acc, e_gwe} = '0;
    @(negedge clk);
    compare_all();
    $display("random compare test done");
    results();
  end
endmodule
`default_nettype wire
